// *** lsd_dimming_ctrl.sv ***
// Top of the LED string dimming control with its Wishbone register slave
`timescale 1ns/10ps
`default_nettype none
module lsd_dimming_ctrl
  import lsd_pkg::*;
#(
  parameter int unsigned ZERO_TIMEOUT_CYC = ZERO_DUTY_CYC,
  parameter int unsigned SOFT_START_CLKS  = SOFT_START_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [1:0]  mode_select_a_i,
  input  wire logic [1:0]  mode_select_b_i,
  input  wire logic        pwm_brightness_input_i,
  input  wire logic [7:0]  headroom_voltage_low_i,
  input  wire logic [7:0]  headroom_voltage_high_i,
  input  wire logic        overvoltage_sense_rise_i,
  input  wire logic        overvoltage_sense_fall_i,
  output logic [7:0]       string_current_sink_o,
  output logic [7:0]       dc_level_o,
  output logic             boost_switch_en_o,
  output logic             soft_start_o,
  output logic [7:0]       open_load_protection_o,
  output logic [7:0]       short_circuit_protection_o,
  output logic             device_enabled_o
);
  logic [7:0]  brightness_level_r;
  logic        backlight_on_r;
  logic [15:0] step_len_r;
  logic        ovp_block_r;
  logic [31:0] ss_cnt_r;
  logic        ss_done_r;
  logic [7:0]  pwm_level;
  logic        pwm_idle;
  logic [7:0]  phase;
  lsd_mode_t   mode;
  logic        serial;
  logic        enable_nxt;
  logic [7:0]  level;
  logic [7:0]  pattern;
  logic        wb_req;
  logic [31:0] status;

  // Maps the two three-level selects to a dimming mode
  function automatic lsd_mode_t decode_mode(input logic [1:0] a, input logic [1:0] b);
    lsd_mode_t m;
    m = LSD_OFF;
    case (a)
      PIN_HIGH: begin
        case (b)
          PIN_HIGH: m = LSD_FIXED;
          PIN_LOW:  m = LSD_NODELAY;
          default:  m = LSD_OFF;
        endcase
      end
      PIN_OPEN: begin
        case (b)
          PIN_HIGH: m = LSD_FIXED;
          PIN_LOW:  m = LSD_NODELAY;
          default:  m = LSD_OFF;
        endcase
      end
      PIN_LOW: begin
        case (b)
          PIN_LOW:  m = LSD_DIRECT;
          PIN_OPEN: m = LSD_DC;
          PIN_HIGH: m = LSD_DC;
          default:  m = LSD_OFF;
        endcase
      end
      // Invalid code 3 leaves the strings dark
      default: m = LSD_OFF;
    endcase
    return m;
  endfunction : decode_mode

  // Serial interface is chosen by select A high, or A low with B high
  function automatic logic decode_serial(input logic [1:0] a, input logic [1:0] b);
    return (a == PIN_HIGH) || (a == PIN_LOW && b == PIN_HIGH);
  endfunction : decode_serial

  // Compare of a string's shifted phase against the level
  function automatic logic str_on(input logic [7:0] ph, input logic [7:0] off,
                                  input logic [7:0] lvl);
    logic [7:0] p;
    p = ph - off;
    return (lvl == LEVEL_MAX) || (p < lvl);
  endfunction : str_on

  lsd_duty_extract #(
    .IDLE_CYC (ZERO_TIMEOUT_CYC)
  ) u_extract (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pwm_i   (pwm_brightness_input_i),
    .level_o (pwm_level),
    .idle_o  (pwm_idle)
  );

  lsd_dim_osc u_osc (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .step_len_i (step_len_r),
    .phase_o    (phase)
  );

  always_comb begin
    mode   = decode_mode(mode_select_a_i, mode_select_b_i);
    serial = decode_serial(mode_select_a_i, mode_select_b_i);
    // Serial modes ignore the input and dim from the stored value
    level  = serial ? brightness_level_r : pwm_level;
    // Serial side obeys the on bit, PWM side the input idle detect
    enable_nxt = (mode != LSD_OFF) && (serial ? backlight_on_r : !pwm_idle);
  end

  always_comb begin
    pattern = '0;
    for (int i = 0; i < NUM_STR; i++) begin
      case (mode)
        LSD_FIXED:   pattern[i] = str_on(phase, 8'(i) * STAGGER, level);
        LSD_NODELAY: pattern[i] = str_on(phase, LEVEL_MIN, level);
        LSD_DIRECT:  pattern[i] = pwm_brightness_input_i;
        LSD_DC:      pattern[i] = 1'b1;
        default:     pattern[i] = 1'b0;
      endcase
    end
  end

  // Enable is registered so it moves on the same edge as the boost, soft start and sink outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      device_enabled_o <= 1'b0;
    end else begin
      device_enabled_o <= enable_nxt;
    end
  end

  // Soft start restarts on each enable; off is immediate
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ss_cnt_r  <= '0;
      ss_done_r <= 1'b0;
    end else if (!enable_nxt) begin
      ss_cnt_r  <= '0;
      ss_done_r <= 1'b0;
    end else if (ss_cnt_r < SOFT_START_CLKS) begin
      ss_cnt_r  <= ss_cnt_r + 1'b1;
      ss_done_r <= (ss_cnt_r >= SOFT_START_CLKS - 1);
    end
  end

  // Rise wins, so a chattering sense pin cannot restart switching
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovp_block_r <= 1'b0;
    end else if (overvoltage_sense_rise_i) begin
      ovp_block_r <= 1'b1;
    end else if (overvoltage_sense_fall_i) begin
      ovp_block_r <= 1'b0;
    end
  end

  // Overvoltage gates switching only; the strings keep running
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      boost_switch_en_o <= 1'b0;
    end else begin
      boost_switch_en_o <= enable_nxt && !ovp_block_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      soft_start_o <= 1'b0;
    end else begin
      soft_start_o <= enable_nxt && !ss_done_r;
    end
  end

  // Faults latch while enabled and only clear once the device is off
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      open_load_protection_o <= '0;
    end else if (!device_enabled_o) begin
      open_load_protection_o <= '0;
    end else begin
      // Low headroom only means open once the boost sits at its limit
      open_load_protection_o <= open_load_protection_o
                                | (headroom_voltage_low_i & {NUM_STR{ovp_block_r}});
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      short_circuit_protection_o <= '0;
    end else if (!device_enabled_o) begin
      short_circuit_protection_o <= '0;
    end else begin
      short_circuit_protection_o <= short_circuit_protection_o
                                    | headroom_voltage_high_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      string_current_sink_o <= '0;
    end else begin
      // Strings wait for soft start, well inside the turn-on limit
      string_current_sink_o <= pattern & {NUM_STR{enable_nxt && ss_done_r}}
                               & ~open_load_protection_o
                               & ~short_circuit_protection_o;
    end
  end

  // Outside DC mode the amplitude sits at full scale
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dc_level_o <= LEVEL_MAX;
    end else begin
      dc_level_o <= (mode == LSD_DC) ? level : LEVEL_MAX;
    end
  end

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // Write strobe for one register offset
  function automatic logic wr_hit(input logic req, input logic [3:0] adr,
                                  input logic [3:0] target);
    return req && (adr == target);
  endfunction : wr_hit

  // Brightness only takes writes while a serial mode is selected
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      brightness_level_r <= BRIGHT_RST;
    end else if (wr_hit(wb_req && wb_we_i, wb_adr_i, ADR_BRIGHT) && wb_sel_i[0] && serial) begin
      brightness_level_r <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      backlight_on_r <= 1'b0;
    end else if (wr_hit(wb_req && wb_we_i, wb_adr_i, ADR_CTRL) && wb_sel_i[0]) begin
      backlight_on_r <= wb_dat_i[CTRL_BL_ON];
    end
  end

  // Step length bytes follow their own byte enables
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      step_len_r <= STEP_RST;
    end else if (wr_hit(wb_req && wb_we_i, wb_adr_i, ADR_STEP)) begin
      if (wb_sel_i[0]) step_len_r[7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1]) step_len_r[15:8] <= wb_dat_i[15:8];
    end
  end

  // Status is read-only; writes to its offset are dropped
  always_comb begin
    status = '0;
    status[7:0] = level;
    status[ST_OPEN_LSB +: 8]  = open_load_protection_o;
    status[ST_SHORT_LSB +: 8] = short_circuit_protection_o;
    status[ST_EN]       = device_enabled_o;
    status[ST_SS_DONE]  = ss_done_r;
    status[ST_OVP]      = ovp_block_r;
    status[ST_MODE_LSB +: 3] = mode;
  end

  // Single-wait-state slave; unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  // Read data only changes on a request, so it stands with ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (wb_req) begin
      case (wb_adr_i)
        ADR_BRIGHT: wb_dat_o <= {24'h000000, brightness_level_r};
        ADR_CTRL:   wb_dat_o <= {31'h00000000, backlight_on_r};
        ADR_STEP:   wb_dat_o <= {16'h0000, step_len_r};
        ADR_STATUS: wb_dat_o <= status;
        default:    wb_dat_o <= '0;
      endcase
    end
  end
endmodule : lsd_dimming_ctrl
`default_nettype wire

// *** lsd_pkg.sv ***
// Constants, types and the register map of the LED string dimming control
// Overview of operation
// - A open/B high or both high: fixed delay
// - A open/B low or A high/B low: no delay
// - Both selects low: direct PWM, PWM only
// - A low/B open or B high: DC current
// - Extract input duty 0-100% into 8 bits
// - Disable after input low over 10 ms
// - Hysteresis hides one LSB input jitter
// - Adjustable dimming oscillator sets period reference
// - Fixed delay staggers strings by two steps
// - No delay: all strings switch together
// - Direct: strings follow input level directly
// - DC: strings on, amplitude in 256 steps
// - Low headroom at overvoltage flags open load
// - High headroom disables string as short
// - Overvoltage stops boost until falling threshold
// - Boost soft start of about 1.5 ms
// - Brightness resets full, written only serial
// - Backlight on within 10 ms, off immediately
package lsd_pkg;
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned ZERO_DUTY_MS  = 10;
  localparam int unsigned SOFT_START_US = 1500;
  localparam int unsigned ZERO_DUTY_CYC = ZERO_DUTY_MS * (CLK_HZ / 1000);
  localparam int unsigned SOFT_START_CYC = SOFT_START_US * (CLK_HZ / 1_000_000);

  localparam int unsigned NUM_STR   = 8;
  localparam int unsigned WIN_W     = 16;
  localparam logic [7:0]  STAGGER   = 8'h02;
  localparam logic [7:0]  LEVEL_MAX = 8'hFF;
  localparam logic [7:0]  LEVEL_MIN = 8'h00;
  localparam logic [7:0]  HYST_LSB  = 8'h01;

  // Three-level select pin as seen by the pin detector
  localparam logic [1:0] PIN_LOW  = 2'h0;
  localparam logic [1:0] PIN_OPEN = 2'h1;
  localparam logic [1:0] PIN_HIGH = 2'h2;

  localparam logic [3:0] ADR_BRIGHT = 4'h0;
  localparam logic [3:0] ADR_CTRL   = 4'h4;
  localparam logic [3:0] ADR_STEP   = 4'h8;
  localparam logic [3:0] ADR_STATUS = 4'hC;

  localparam logic [7:0]  BRIGHT_RST = 8'hFF;
  localparam logic [15:0] STEP_RST   = 16'h0186;
  localparam int unsigned CTRL_BL_ON = 0;
  localparam int unsigned ST_OPEN_LSB  = 8;
  localparam int unsigned ST_SHORT_LSB = 16;
  localparam int unsigned ST_EN        = 24;
  localparam int unsigned ST_SS_DONE   = 25;
  localparam int unsigned ST_OVP       = 26;
  localparam int unsigned ST_MODE_LSB  = 27;

  typedef enum logic [2:0] {
    LSD_OFF,
    LSD_FIXED,
    LSD_NODELAY,
    LSD_DIRECT,
    LSD_DC
  } lsd_mode_t;
endpackage : lsd_pkg

// *** lsd_duty_extract.sv ***
// Duty extractor for the PWM brightness input, with hysteresis and idle detect
`timescale 1ns/10ps
`default_nettype none
module lsd_duty_extract
  import lsd_pkg::*;
#(
  parameter int unsigned IDLE_CYC = ZERO_DUTY_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       pwm_i,
  output logic [7:0]      level_o,
  output logic            idle_o
);
  logic [WIN_W-1:0] win_cnt_r;
  logic [WIN_W:0]   high_cnt_r;
  logic [WIN_W:0]   total;
  logic [7:0]       raw;
  logic [7:0]       diff;
  logic [31:0]      low_cnt_r;

  always_comb begin
    total = high_cnt_r + {{WIN_W{1'b0}}, pwm_i};
    // All-high window saturates to full scale
    raw   = total[WIN_W] ? LEVEL_MAX : total[WIN_W-1 -: 8];
    diff  = (raw > level_o) ? raw - level_o : level_o - raw;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      win_cnt_r  <= '0;
      high_cnt_r <= '0;
    end else begin
      win_cnt_r <= win_cnt_r + 1'b1;
      if (&win_cnt_r) begin
        high_cnt_r <= '0;
      end else begin
        high_cnt_r <= total;
      end
    end
  end

  // One-LSB moves are ignored, but the ends stay reachable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_o <= LEVEL_MIN;
    end else if (&win_cnt_r && (diff > HYST_LSB || raw == LEVEL_MIN || raw == LEVEL_MAX)) begin
      level_o <= raw;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_cnt_r <= '0;
      idle_o    <= 1'b1;
    end else begin
      if (pwm_i) begin
        low_cnt_r <= '0;
      end else if (low_cnt_r < IDLE_CYC) begin
        low_cnt_r <= low_cnt_r + 1'b1;
      end
      idle_o <= !pwm_i && (low_cnt_r >= IDLE_CYC - 1);
    end
  end
endmodule : lsd_duty_extract
`default_nettype wire

// *** lsd_dim_osc.sv ***
// Dimming oscillator: 256 phase steps per dimming period
`timescale 1ns/10ps
`default_nettype none
module lsd_dim_osc
  import lsd_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [15:0] step_len_i,
  output logic [7:0]       phase_o
);
  logic [15:0] step_cnt_r;

  // Period is 256 times the step length in clocks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      step_cnt_r <= '0;
      phase_o    <= '0;
    end else if (step_cnt_r + 16'h0001 >= step_len_i) begin
      step_cnt_r <= '0;
      phase_o    <= phase_o + 8'h01;
    end else begin
      step_cnt_r <= step_cnt_r + 16'h0001;
    end
  end
endmodule : lsd_dim_osc
`default_nettype wire

// *** lsd_dimming_ctrl_properties.sv ***
// Port-level assertions for the dimming control
`timescale 1ns/10ps
`default_nettype none
module lsd_dimming_ctrl_properties (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic [7:0] headroom_voltage_low_i,
  input wire logic [7:0] headroom_voltage_high_i,
  input wire logic       overvoltage_sense_rise_i,
  input wire logic [7:0] string_current_sink_o,
  input wire logic       boost_switch_en_o,
  input wire logic       soft_start_o,
  input wire logic [7:0] open_load_protection_o,
  input wire logic [7:0] short_circuit_protection_o,
  input wire logic       device_enabled_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ss_dark: assert property (soft_start_o |-> string_current_sink_o == 8'h00)
    else $error("strings on in soft start");
  a_ovp_stop: assert property (overvoltage_sense_rise_i |-> ##[1:2] !boost_switch_en_o)
    else $error("boost kept switching");
  a_short_cause: assert property (((short_circuit_protection_o
    & ~$past(short_circuit_protection_o)) & ~$past(headroom_voltage_high_i)) == 8'h00)
    else $error("short flag without cause");
  a_open_cause: assert property (((open_load_protection_o
    & ~$past(open_load_protection_o)) & ~$past(headroom_voltage_low_i)) == 8'h00)
    else $error("open flag without cause");
  a_fault_dark: assert property ((string_current_sink_o
    & $past(open_load_protection_o | short_circuit_protection_o)) == 8'h00)
    else $error("faulted string driven");
  a_fault_hold: assert property (device_enabled_o && $past(device_enabled_o) |->
    ($past(open_load_protection_o | short_circuit_protection_o)
    & ~(open_load_protection_o | short_circuit_protection_o)) == 8'h00)
    else $error("fault cleared while enabled");
endmodule : lsd_dimming_ctrl_properties
`default_nettype wire

// *** lsd_pwm_host.sv ***
// Host-side PWM brightness source with programmable duty
`timescale 1ns/10ps
`default_nettype none
module lsd_pwm_host (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [15:0] high_i,
  input  wire logic [15:0] period_i,
  output var logic         pwm_o
);
  logic [15:0] cnt_r;
  // Zero period parks the line low, as an idle host would
  always_ff @(posedge clk_i) begin
    if (rst_i || period_i == 16'h0000 || cnt_r >= period_i - 16'h0001) begin
      cnt_r <= 16'h0000;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end
  always_ff @(posedge clk_i) begin
    pwm_o <= !rst_i && period_i != 16'h0000 && cnt_r < high_i;
  end
endmodule : lsd_pwm_host
`default_nettype wire

// *** lsd_dimming_ctrl_tb.sv ***
// Self-checking bench for the LED string dimming control
`timescale 1ns/10ps
`default_nettype none
module lsd_dimming_ctrl_tb;
  import lsd_pkg::*;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0]  adr = 4'h0, sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic        ack, pwm, ovr = 1'b0, ovf = 1'b0, bst, ss, den;
  logic [1:0]  sa = 2'h3, sb = 2'h3;
  logic [7:0]  hlo = 8'h00, hhi = 8'h00, sink, dcl, open_load_protection, short_circuit_protection;
  logic [15:0] hi_c = 16'h0, per_c = 16'h0;
  int          error_cnt = 0, checks = 0;
  always #5 clk_i = ~clk_i;
  lsd_pwm_host u_lsd_pwm_host (.clk_i(clk_i), .rst_i(rst_i), .high_i(hi_c),
    .period_i(per_c), .pwm_o(pwm));
  lsd_dimming_ctrl #(.ZERO_TIMEOUT_CYC(200), .SOFT_START_CLKS(50)) u_lsd_dimming_ctrl (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .mode_select_a_i(sa), .mode_select_b_i(sb), .pwm_brightness_input_i(pwm),
    .headroom_voltage_low_i(hlo), .headroom_voltage_high_i(hhi),
    .overvoltage_sense_rise_i(ovr), .overvoltage_sense_fall_i(ovf),
    .string_current_sink_o(sink), .dc_level_o(dcl), .boost_switch_en_o(bst),
    .soft_start_o(ss), .open_load_protection_o(open_load_protection),
    .short_circuit_protection_o(short_circuit_protection), .device_enabled_o(den));
  task automatic conclude;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  // Classic cycle; ack and data are read at the edge that sees ack
  // Only the watchdog ends a wait for ack
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
    do begin @(posedge clk_i); end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0;
    @(posedge clk_i);
    chk("ack drop", 0, ack);
  endtask : wb
  task automatic wait_on;
    int n;
    n = 0;
    while (ss !== 1'b1 && n < 400) begin @(posedge clk_i); n++; end
    while (ss !== 1'b0 && n < 400) begin @(posedge clk_i); n++; end
    repeat (3) @(posedge clk_i);
    chk("soft start end", 1, n < 400);
  endtask : wait_on
  // PWM-side DC mode; 3/7 duty over the first full window gives 6Dh
  task automatic t_duty;
    sa <= 2'h0; sb <= 2'h1; hi_c <= 16'h3; per_c <= 16'h7;
    repeat (65000) @(posedge clk_i);
    chk("duty hold", 0, dcl); chk("pwm enable", 1, den);
    repeat (600) @(posedge clk_i);
    chk("duty dc level", 32'h6D, dcl);
    wb(0, ADR_STATUS, 0); chk("duty level", 32'h6D, q[7:0]);
    per_c <= 16'h0;
  endtask : t_duty
  // Mid-run reset brings outputs and brightness back
  task automatic t_rst;
    rst_i <= 1'b1; repeat (5) @(posedge clk_i);
    chk("rst dc level", 32'hFF, dcl); chk("rst enable", 0, den);
    rst_i <= 1'b0; @(posedge clk_i);
    wb(0, ADR_BRIGHT, 0); chk("rst bright", 32'hFF, q);
  endtask : t_rst
  task automatic t_regs;
    wb(0, ADR_BRIGHT, 0); chk("bright rst", 32'hFF, q);
    wb(0, ADR_CTRL, 0); chk("ctrl rst", 0, q);
    wb(0, ADR_STEP, 0); chk("step rst", 32'h186, q);
    wb(0, 4'h2, 0); chk("unmapped", 0, q);
    wb(1, ADR_BRIGHT, 32'h12); wb(0, ADR_BRIGHT, 0); chk("bright locked", 32'hFF, q);
  endtask : t_regs
  task automatic t_modes;
    logic [1:0] ta[9] = '{2'h2, 2'h1, 2'h1, 2'h2, 2'h0, 2'h0, 2'h0, 2'h2, 2'h0};
    logic [1:0] tb[9] = '{2'h2, 2'h2, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h1, 2'h3};
    lsd_mode_t tm[9] = '{LSD_FIXED, LSD_FIXED, LSD_NODELAY, LSD_NODELAY, LSD_DIRECT,
      LSD_DC, LSD_DC, LSD_OFF, LSD_OFF};
    for (int i = 0; i < 9; i++) begin
      sa <= ta[i]; sb <= tb[i];
      repeat (3) @(posedge clk_i);
      wb(0, ADR_STATUS, 0); chk("mode", tm[i], q[29:27]);
    end
  endtask : t_modes
  // Serial dimming at level 40h; step 4 gives a 1024-cycle period
  task automatic t_pat(input logic [1:0] a, input logic [1:0] b, input int gap);
    int cnt[8], rise[8];
    logic [7:0] prev;
    sa <= a; sb <= b;
    wb(1, ADR_STEP, 4); wb(1, ADR_BRIGHT, 32'h40); wb(1, ADR_CTRL, 1);
    wait_on();
    cnt = '{default: 0}; rise = '{default: 0}; prev = sink;
    for (int k = 0; k < 1024; k++) begin
      @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
        cnt[i] += sink[i];
        if (sink[i] && !prev[i]) rise[i] = k;
      end
      prev = sink;
    end
    for (int i = 0; i < 8; i++) begin
      chk("on cycles", 256, cnt[i]);
      chk("stagger", gap * i, (rise[i] - rise[0] + 1024) % 1024);
    end
    wb(0, ADR_STATUS, 0); chk("level used", 32'h40, q[7:0]);
    wb(1, ADR_CTRL, 0);
    chk("off enable", 0, den); chk("off sinks", 0, sink);
  endtask : t_pat
  task automatic t_dc;
    sa <= 2'h0; sb <= 2'h2;
    wb(1, ADR_BRIGHT, 32'h5A); wb(1, ADR_CTRL, 1);
    wait_on();
    chk("dc level", 32'h5A, dcl); chk("dc sinks", 32'hFF, sink);
    hhi <= 8'h08; repeat (4) @(posedge clk_i); hhi <= 8'h00;
    hlo <= 8'h01; ovr <= 1'b1; repeat (4) @(posedge clk_i);
    chk("boost stop", 0, bst); chk("open", 1, open_load_protection);
    ovr <= 1'b0; ovf <= 1'b1; hlo <= 8'h00; repeat (4) @(posedge clk_i); ovf <= 1'b0;
    chk("boost resume", 1, bst); chk("short held", 8, short_circuit_protection);
    chk("faulted dark", 32'hF6, sink);
    wb(1, ADR_CTRL, 0); repeat (2) @(posedge clk_i);
    chk("faults cleared", 0, {open_load_protection, short_circuit_protection});
  endtask : t_dc
  task automatic t_direct;
    logic p;
    sa <= 2'h0; sb <= 2'h0; hi_c <= 16'h3; per_c <= 16'h7;
    wait_on();
    p = pwm;
    repeat (20) begin
      @(posedge clk_i); chk("direct", {8{p}}, sink); p = pwm;
    end
    per_c <= 16'h0; repeat (215) @(posedge clk_i);
    chk("idle off", 0, den);
  endtask : t_direct
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_duty(); t_regs(); t_modes();
    t_pat(2'h2, 2'h2, 8);
    t_pat(2'h2, 2'h0, 0);
    t_dc(); t_rst(); t_direct();
    conclude();
  end
  initial begin
    repeat (90000) @(posedge clk_i);
    error_cnt++;
    conclude();
  end
endmodule : lsd_dimming_ctrl_tb
bind lsd_dimming_ctrl lsd_dimming_ctrl_properties u_lsd_dimming_ctrl_properties (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .headroom_voltage_low_i(headroom_voltage_low_i),
  .headroom_voltage_high_i(headroom_voltage_high_i),
  .overvoltage_sense_rise_i(overvoltage_sense_rise_i),
  .string_current_sink_o(string_current_sink_o), .boost_switch_en_o(boost_switch_en_o),
  .soft_start_o(soft_start_o), .open_load_protection_o(open_load_protection_o),
  .short_circuit_protection_o(short_circuit_protection_o),
  .device_enabled_o(device_enabled_o));
`default_nettype wire
